// ==== phcp_pkg.sv ====
// package of constants for the host control pin block
`default_nettype none
package phcp_pkg;
	localparam int unsigned N_IRQ         = 4;
	localparam int unsigned N_RAIL        = 7;
	localparam int unsigned LINEAR_ONE    = 3;
	localparam int unsigned LINEAR_TWO    = 4;
	localparam int unsigned CLK_HZ        = 40000000;
	localparam int unsigned RESTART_MS    = 1000;
	localparam int unsigned RESTART_CYC   = (CLK_HZ / 1000) * RESTART_MS;
	localparam int unsigned WAKE_CYC      = 16;
	localparam logic [3:0]  MASK_RESET    = 4'h0;
	localparam int unsigned IRQ_BUTTON    = 0;
	localparam int unsigned IRQ_POWER_ON  = 1;
	typedef enum logic [1:0] {PHCP_OFF, PHCP_WAIT, PHCP_ON} phcp_state_e;
endpackage : phcp_pkg
`default_nettype wire

// ==== phcp_flags_if.sv ====
// interface carrying interrupt flag traffic between top and flag unit
`timescale 1ns/10ps
`default_nettype none
interface phcp_flags_if #(parameter int unsigned N = 4);
	logic [N-1:0] event_set;
	logic [N-1:0] mask;
	logic [N-1:0] read_clr;
	logic [N-1:0] flags;
	logic         irq_req;
	modport top (output event_set, output mask, output read_clr, input flags, input irq_req);
	modport unit (input event_set, input mask, input read_clr, output flags, output irq_req);
endinterface : phcp_flags_if
`default_nettype wire

// ==== phcp_flags.sv ====
// sticky interrupt flags with per-source mask
`timescale 1ns/10ps
`default_nettype none
module phcp_flags #(
	parameter int unsigned N = 4
) (
	input  wire logic   core_clk,
	input  wire logic   rst,
	phcp_flags_if.unit  fl
);
	logic [N-1:0] flags_q;
	logic [N-1:0] flags_d;
	logic         irq_q;

	// set beats read-clear so a coincident event is kept
	assign flags_d = (flags_q & ~fl.read_clr) | fl.event_set;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flags_q <= '0;
			irq_q   <= 1'b0;
		end else begin
			flags_q <= flags_d;
			irq_q   <= |(flags_d & ~fl.mask);
		end
	end

	assign fl.flags   = flags_q;
	assign fl.irq_req = irq_q;

	a_masked_quiet: assert property (@(posedge core_clk) disable iff (rst)
		(irq_q |-> |(flags_q & ~$past(fl.mask))))
		else $error("irq without unmasked flag");
	a_set_holds: assert property (@(posedge core_clk) disable iff (rst)
		(|(fl.event_set & ~fl.mask) |=> irq_q))
		else $error("unmasked event gave no irq");
endmodule : phcp_flags
`default_nettype wire

// ==== phcp_top.sv ====
// host control pins: interrupt, shutdown/restart, enable, power-good, wake, button
`timescale 1ns/10ps
`default_nettype none
module phcp_top #(
	parameter int unsigned RESTART_CYC = phcp_pkg::RESTART_CYC,
	parameter int unsigned N_IRQ       = phcp_pkg::N_IRQ
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic                       shutdown_n_in,
	input  wire logic                       rail_enable_in,
	input  wire logic                       button_n_in,
	input  wire logic [phcp_pkg::N_RAIL-1:0] rail_in_reg,
	input  wire logic [N_IRQ-1:0]           irq_mask,
	input  wire logic [N_IRQ-1:0]           flag_read,
	input  wire logic [N_IRQ-1:0]           ext_event,
	output logic [phcp_pkg::N_RAIL-1:0]     rail_on_out,
	output logic [N_IRQ-1:0]                flags_out,
	output logic                            button_pressed_out,
	output logic                            irq_n_out,
	output logic                            irq_n_oe,
	output logic                            wake_n_out,
	output logic                            wake_n_oe,
	output logic                            rails_ok_out,
	output logic                            linear_rails_ok_out
);
	// =====================================================================
	// power state
	phcp_pkg::phcp_state_e state_q;
	phcp_pkg::phcp_state_e state_d;
	logic [31:0]           delay_q;
	logic [31:0]           delay_d;
	logic                  delay_done;
	logic                  power_on_ev;
	logic                  powered;

	assign delay_done = (delay_q >= RESTART_CYC - 1);
	assign powered    = (state_q == phcp_pkg::PHCP_ON);

	always_comb begin
		state_d = state_q;
		delay_d = '0;
		case (state_q)
			phcp_pkg::PHCP_OFF: begin
				if (shutdown_n_in) begin
					state_d = phcp_pkg::PHCP_WAIT;
				end
			end
			phcp_pkg::PHCP_WAIT: begin
				delay_d = delay_q + 32'h1;
				if (delay_done) begin
					state_d = phcp_pkg::PHCP_ON;
				end
			end
			phcp_pkg::PHCP_ON: begin
			end
			default: state_d = phcp_pkg::PHCP_OFF;
		endcase
		if (!shutdown_n_in) begin
			state_d = phcp_pkg::PHCP_OFF;
			delay_d = '0;
		end
	end

	// first cycle of a power-up with enable present
	logic sequencing_q;
	assign power_on_ev = powered && rail_enable_in && !sequencing_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q      <= phcp_pkg::PHCP_OFF;
			delay_q      <= '0;
			sequencing_q <= 1'b0;
		end else begin
			state_q      <= state_d;
			delay_q      <= delay_d;
			sequencing_q <= (state_d == phcp_pkg::PHCP_ON) && rail_enable_in && powered;
		end
	end

	// =====================================================================
	// rail enables and power-good
	logic                        rails_go;
	logic [phcp_pkg::N_RAIL-1:0] rail_bad;
	logic                        rails_ok_d;
	logic                        linear_ok_d;
	assign rails_go = powered && rail_enable_in && shutdown_n_in;
	assign rail_bad = rail_on_out & ~rail_in_reg;
	// a rail only counts as bad once it is switched on, so good rises with the enable
	assign rails_ok_d  = rails_go && (rail_bad == '0);
	assign linear_ok_d = rails_go && !rail_bad[phcp_pkg::LINEAR_ONE]
		&& !rail_bad[phcp_pkg::LINEAR_TWO];

	// =====================================================================
	// wake pulse and button
	logic [4:0] wake_cnt_q;
	logic [4:0] wake_cnt_d;
	logic       wake_oe_d;
	logic       button_q;
	logic       button_edge;
	logic       button_seen_d;
	// pin held for the whole count, then let go
	assign wake_cnt_d    = power_on_ev ? 5'(phcp_pkg::WAKE_CYC)
		: (wake_cnt_q != '0 ? wake_cnt_q - 5'h1 : '0);
	assign wake_oe_d     = (power_on_ev || wake_cnt_q > 5'h1) && shutdown_n_in;
	// button_q resets to the idle level, so leaving reset makes no false press
	assign button_edge   = !button_n_in && !button_q;
	assign button_seen_d = !button_n_in && shutdown_n_in;

	// =====================================================================
	// interrupt flags
	phcp_flags_if #(.N(N_IRQ)) fl ();
	logic [N_IRQ-1:0] ev;
	always_comb begin
		ev = ext_event;
		ev[phcp_pkg::IRQ_BUTTON]   = ext_event[phcp_pkg::IRQ_BUTTON] | button_edge;
		ev[phcp_pkg::IRQ_POWER_ON] = ext_event[phcp_pkg::IRQ_POWER_ON] | power_on_ev;
	end
	assign fl.event_set = ev;
	assign fl.mask      = irq_mask;
	// shutdown wipes the flags so a restart comes up at defaults
	assign fl.read_clr  = flag_read | {N_IRQ{!shutdown_n_in}};
	logic             irq_oe_d;
	assign irq_oe_d     = fl.irq_req && shutdown_n_in;

	phcp_flags #(.N(N_IRQ)) u_flags (
		.core_clk (core_clk),
		.rst      (rst),
		.fl       (fl)
	);

	// =====================================================================
	// output registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rail_on_out         <= '0;
			rails_ok_out        <= 1'b0;
			linear_rails_ok_out <= 1'b0;
		end else begin
			rail_on_out         <= rails_go ? '1 : '0;
			rails_ok_out        <= rails_ok_d;
			linear_rails_ok_out <= linear_ok_d;
		end
	end

	// open-drain pins: data stays low, the enable does the signalling
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_n_out <= 1'b0;
			irq_n_oe  <= 1'b0;
		end else begin
			irq_n_out <= 1'b0;
			irq_n_oe  <= irq_oe_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wake_n_out <= 1'b0;
			wake_n_oe  <= 1'b0;
			wake_cnt_q <= '0;
		end else begin
			wake_n_out <= 1'b0;
			wake_n_oe  <= wake_oe_d;
			wake_cnt_q <= wake_cnt_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			button_q           <= 1'b0;
			button_pressed_out <= 1'b0;
			flags_out          <= '0;
		end else begin
			button_q           <= !button_n_in;
			button_pressed_out <= button_seen_d;
			flags_out          <= fl.flags;
		end
	end

	// =====================================================================
	// checks
	a_off_no_rails: assert property (@(posedge core_clk) disable iff (rst)
		(!shutdown_n_in |=> rail_on_out == '0))
		else $error("rails on in shutdown");
	a_shutdown_quiet: assert property (@(posedge core_clk) disable iff (rst)
		(!shutdown_n_in |=> !irq_n_oe && !wake_n_oe && !button_pressed_out
			&& !rails_ok_out && !linear_rails_ok_out))
		else $error("output active in shutdown");
	a_wait_no_rails: assert property (@(posedge core_clk) disable iff (rst)
		(state_q == phcp_pkg::PHCP_WAIT |=> rail_on_out == '0))
		else $error("rails on during restart delay");
	a_restart_wait: assert property (@(posedge core_clk) disable iff (rst)
		(state_q == phcp_pkg::PHCP_WAIT && delay_q < RESTART_CYC - 1 && shutdown_n_in
			|=> state_q == phcp_pkg::PHCP_WAIT))
		else $error("restart delay cut short");
	a_wake_pulse: assert property (@(posedge core_clk) disable iff (rst)
		(power_on_ev && shutdown_n_in |=> wake_n_oe))
		else $error("no wake on power-on");
	a_power_flag: assert property (@(posedge core_clk) disable iff (rst)
		(power_on_ev |=> fl.flags[phcp_pkg::IRQ_POWER_ON]))
		else $error("power-on flag not set");
	a_rails_ok: assert property (@(posedge core_clk) disable iff (rst)
		(rails_go && rail_bad != '0 |=> !rails_ok_out))
		else $error("global good high with bad rail");
	a_rails_good: assert property (@(posedge core_clk) disable iff (rst)
		(rails_go && rail_bad == '0 |=> rails_ok_out))
		else $error("global good low with rails fine");
	a_linear_ok: assert property (@(posedge core_clk) disable iff (rst)
		(rail_bad[phcp_pkg::LINEAR_ONE] |=> !linear_rails_ok_out))
		else $error("linear good high with bad linear");
	a_linear_two: assert property (@(posedge core_clk) disable iff (rst)
		(rail_bad[phcp_pkg::LINEAR_TWO] |=> !linear_rails_ok_out))
		else $error("linear good high with bad second linear");
	a_linear_other: assert property (@(posedge core_clk) disable iff (rst)
		(rails_go && !rail_bad[phcp_pkg::LINEAR_ONE] && !rail_bad[phcp_pkg::LINEAR_TWO]
			|=> linear_rails_ok_out))
		else $error("linear good pulled by other rail");
	a_irq_pin: assert property (@(posedge core_clk) disable iff (rst)
		(fl.irq_req && shutdown_n_in |=> irq_n_oe))
		else $error("irq pin not driven");
	a_irq_sticky: assert property (@(posedge core_clk) disable iff (rst)
		(fl.irq_req && flag_read == '0 && shutdown_n_in && irq_mask == $past(irq_mask)
			|=> fl.irq_req))
		else $error("irq dropped without a read");
	a_button_seen: assert property (@(posedge core_clk) disable iff (rst)
		(!button_n_in && shutdown_n_in |=> button_pressed_out))
		else $error("press not seen");
	a_button_flag: assert property (@(posedge core_clk) disable iff (rst)
		(button_edge |=> fl.flags[phcp_pkg::IRQ_BUTTON]))
		else $error("press flag not set");
endmodule : phcp_top
`default_nettype wire

// ==== phcp_host_model.sv ====
// host processor model: with ack_en set, reads back flags while the interrupt line is low
`timescale 1ns/10ps
`default_nettype none
module phcp_host_model (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       ack_en,
	input  wire logic       irq_pin,
	input  wire logic [3:0] flags_seen,
	output var  logic [3:0] flag_read
);
	// flags_seen lags, so a repeated read of a cleared bit is expected and harmless
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			flag_read <= 4'h0;
		else
			flag_read <= (ack_en && !irq_pin) ? flags_seen : 4'h0;
	end
endmodule // phcp_host_model
`default_nettype wire

// ==== phcp_top_tb_top.sv ====
// testbench for the host control pin block
`timescale 1ns/10ps
`default_nettype none
module phcp_top_tb_top;
	localparam int unsigned RC = 20;
	localparam logic [6:0]  PAT [4] = '{7'h7f, 7'h7e, 7'h77, 7'h6f};
	logic       core_clk = 1'b0;
	logic       rst = 1'b1;
	logic       shutdown_n_in = 1'b0;
	logic       rail_enable_in = 1'b0;
	logic       button_n_in = 1'b1;
	logic       ack_en = 1'b0;
	logic [6:0] rail_in_reg = 7'h7f;
	logic [3:0] irq_mask = 4'h0;
	logic [3:0] ext_event = 4'h0;
	logic [3:0] flag_read, flags_out;
	logic [6:0] rail_on_out;
	logic       button_pressed_out, irq_n_out, irq_n_oe, wake_n_out, wake_n_oe;
	logic       rails_ok_out, linear_rails_ok_out;
	int         fails = 0;
	int         samples_checked = 0;
	// open-drain interrupt line with a pull-up
	wire        irq_pin = irq_n_oe ? irq_n_out : 1'b1;
	always #12.5 core_clk = ~core_clk;
	phcp_top #(.RESTART_CYC(RC)) u_phcp_top (.core_clk, .rst, .shutdown_n_in, .rail_enable_in,
		.button_n_in, .rail_in_reg, .irq_mask, .flag_read, .ext_event, .rail_on_out,
		.flags_out, .button_pressed_out, .irq_n_out, .irq_n_oe, .wake_n_out, .wake_n_oe,
		.rails_ok_out, .linear_rails_ok_out);
	phcp_host_model u_phcp_host_model (.core_clk, .rst, .ack_en, .irq_pin,
		.flags_seen(flags_out), .flag_read);
	task automatic check(input logic [6:0] seen, input logic [6:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic t_power_up();
		@(posedge core_clk);
		shutdown_n_in <= 1'b1;
		rail_enable_in <= 1'b1;
		step(RC - 2);
		check(rail_on_out, 7'h00);
		step(6);
		check(rail_on_out, 7'h7f);
		check(7'(wake_n_oe && !wake_n_out), 7'h01);
		check(7'({flags_out, irq_pin}), 7'h04);
		@(posedge core_clk);
		ack_en <= 1'b1;
		step(6);
		check(7'({flags_out, irq_pin}), 7'h01);
	endtask
	task automatic t_mask();
		@(posedge core_clk);
		ack_en <= 1'b0;
		irq_mask <= 4'h4;
		ext_event <= 4'h4;
		@(posedge core_clk);
		ext_event <= 4'h0;
		step(4);
		check(7'({flags_out, irq_pin}), 7'h09);
		@(posedge core_clk);
		ext_event <= 4'h8;
		@(posedge core_clk);
		ext_event <= 4'h0;
		step(4);
		check(7'({flags_out, irq_pin}), 7'h18);
		@(posedge core_clk);
		ack_en <= 1'b1;
		step(6);
		check(7'({flags_out, irq_pin}), 7'h01);
	endtask
	task automatic t_good();
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			rail_in_reg <= PAT[i];
			step(3);
			check(7'(rails_ok_out), 7'(&PAT[i]));
			check(7'(linear_rails_ok_out), 7'(PAT[i][3] & PAT[i][4]));
		end
		@(posedge core_clk);
		rail_in_reg <= 7'h7f;
	endtask
	task automatic t_button();
		@(posedge core_clk);
		ack_en <= 1'b0;
		button_n_in <= 1'b0;
		step(4);
		check(7'(button_pressed_out), 7'h01);
		check(7'({flags_out, irq_pin}), 7'h02);
		@(posedge core_clk);
		button_n_in <= 1'b1;
		step(3);
		check(7'(button_pressed_out), 7'h00);
	endtask
	// shutdown with flags pending, then a full restart
	task automatic t_shutdown();
		@(posedge core_clk);
		ext_event <= 4'h8;
		@(posedge core_clk);
		ext_event <= 4'h0;
		step(1);
		check(7'({flags_out, irq_pin}), 7'h12);
		@(posedge core_clk);
		shutdown_n_in <= 1'b0;
		step(2);
		check(rail_on_out, 7'h00);
		check(7'(irq_n_oe), 7'h00);
		check(7'({wake_n_oe, button_pressed_out, rails_ok_out}), 7'h00);
		check(7'(flags_out), 7'h00);
		@(posedge core_clk);
		shutdown_n_in <= 1'b1;
		step(RC - 2);
		check(rail_on_out, 7'h00);
		step(6);
		check(rail_on_out, 7'h7f);
		check(7'({flags_out, irq_pin}), 7'h04);
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		t_power_up();
		t_mask();
		t_good();
		t_button();
		t_shutdown();
		results();
	end
	// whole sequence takes well under 200 cycles
	initial begin
		repeat (2000) @(posedge core_clk);
		fails++;
		results();
	end
endmodule // phcp_top_tb_top
`default_nettype wire
